// *** src/pwm_fault_trigger_logic.sv ***
`timescale 1ns/1ps
module pwm_fault_trigger_logic #(
    parameter bit HAS_EXT = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pwm_fault_pkg::ADDR_W-1:0] paddr,
    input wire logic [pwm_fault_pkg::DATA_W-1:0] pwdata,
    output logic [pwm_fault_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [pwm_fault_pkg::NUM_PIN-1:0] external_fault_input,
    input wire logic [pwm_fault_pkg::NUM_GEN-1:0][pwm_fault_pkg::NUM_DCMP-1:0]
        dcmp_trig,
    output logic [pwm_fault_pkg::NUM_GEN-1:0] count_advance,
    output logic [pwm_fault_pkg::NUM_GEN-1:0] gen_fault,
    output logic irq
);

    localparam int NG = pwm_fault_pkg::NUM_GEN;
    localparam int NP = pwm_fault_pkg::NUM_PIN;
    localparam int ND = pwm_fault_pkg::NUM_DCMP;

    typedef struct packed {
        logic [NG-1:0] en;
        logic [NG-1:0] latch;
        logic [NG-1:0] minper;
        logic [NG-1:0] ext;
        logic [NG-1:0][NP-1:0] sense;
        logic [NG-1:0][NP-1:0] sel0;
        logic [NG-1:0][ND-1:0] sel1;
        logic [NG-1:0][pwm_fault_pkg::MIN_W-1:0] min_cycles;
        logic [NG-1:0][pwm_fault_pkg::CNT_W-1:0] count;
        logic [NG-1:0] fault_prev;
        logic [NG-1:0] int_status;
        logic [NG-1:0] int_mask;
        logic [pwm_fault_pkg::DATA_W-1:0] rdata;
    } top_state_t;

    top_state_t st_reg;
    top_state_t st_next;
    logic [NG-1:0][NP-1:0] stat0_w;
    logic [NG-1:0][ND-1:0] stat1_w;
    logic [NG-1:0][NP-1:0] clr0_w;
    logic [NG-1:0][ND-1:0] clr1_w;
    logic [NG-1:0] fault_w;
    logic wr_go;
    logic rd_setup;
    logic [pwm_fault_pkg::GEN_W-1:0] gsel;
    logic [pwm_fault_pkg::IDX_W-1:0] idx;

    // ------------------------------------------------------------
    // Address decode helpers
    // ------------------------------------------------------------
    // Misaligned and unused global words are reported as errors
    function automatic logic is_mapped(
        input logic [pwm_fault_pkg::ADDR_W-1:0] a
    );
        logic ok;
        ok = 1'b0;
        if (a[1:0] != pwm_fault_pkg::ALIGN_OK) begin
            ok = 1'b0;
        end else if (!a[pwm_fault_pkg::GLOBAL_BIT]) begin
            ok = 1'b1;
        end else begin
            ok = (a == pwm_fault_pkg::OFF_INT_STATUS) ||
                (a == pwm_fault_pkg::OFF_INT_MASK);
        end
        return ok;
    endfunction

    function automatic logic gen_reg_hit(
        input logic [pwm_fault_pkg::ADDR_W-1:0] a,
        input logic [pwm_fault_pkg::IDX_W-1:0] want
    );
        logic hit;
        hit = !a[pwm_fault_pkg::GLOBAL_BIT] &&
            (a[pwm_fault_pkg::IDX_LSB +: pwm_fault_pkg::IDX_W] == want);
        return hit;
    endfunction

    // ------------------------------------------------------------
    // Per-generator fault units
    // ------------------------------------------------------------
    fault_if fi[NG]();

    for (genvar g = 0; g < NG; g++) begin : gen_unit
        assign fi[g].sense = st_reg.sense[g];
        assign fi[g].sel0 = st_reg.sel0[g];
        assign fi[g].sel1 = st_reg.sel1[g];
        assign fi[g].minimum_fault_cycles = st_reg.min_cycles[g];
        assign fi[g].latched_fault_mode = st_reg.latch[g];
        assign fi[g].min_fault_period_mode = st_reg.minper[g];
        assign fi[g].extended_fault_source_mode = st_reg.ext[g];
        assign fi[g].clr0 = clr0_w[g];
        assign fi[g].clr1 = clr1_w[g];
        assign stat0_w[g] = fi[g].stat0;
        assign stat1_w[g] = fi[g].stat1;
        assign fault_w[g] = fi[g].fault;

        fault_unit #(
            .HAS_EXT(HAS_EXT)
        ) u_unit (
            .pclk(pclk),
            .presetn(presetn),
            .external_fault_input(external_fault_input),
            .dcmp_trig(dcmp_trig[g]),
            .f(fi[g])
        );
    end

    // ------------------------------------------------------------
    // Register file, counters and interrupt status
    // ------------------------------------------------------------
    // Read data is captured in the setup phase so prdata is a flop
    always_comb begin
        st_next = st_reg;
        wr_go = psel & penable & pwrite & is_mapped(paddr);
        rd_setup = psel & ~penable & ~pwrite;
        gsel = paddr[pwm_fault_pkg::GEN_LSB +: pwm_fault_pkg::GEN_W];
        idx = paddr[pwm_fault_pkg::IDX_LSB +: pwm_fault_pkg::IDX_W];
        clr0_w = '0;
        clr1_w = '0;
        // Gated counters: a disabled generator simply holds
        for (int g = 0; g < NG; g++) begin
            if (st_reg.en[g]) begin
                st_next.count[g] = st_reg.count[g] + pwm_fault_pkg::CNT_ONE;
            end else begin
                st_next.count[g] = st_reg.count[g];
            end
        end
        // Fault onset events; a new event beats a same-cycle clear
        st_next.fault_prev = fault_w;
        if (wr_go && paddr == pwm_fault_pkg::OFF_INT_STATUS) begin
            st_next.int_status = st_reg.int_status & ~pwdata[NG-1:0];
        end
        st_next.int_status = st_next.int_status |
            (fault_w & ~st_reg.fault_prev);
        if (wr_go && paddr == pwm_fault_pkg::OFF_INT_MASK) begin
            st_next.int_mask = pwdata[NG-1:0];
        end
        // Generator register writes
        if (wr_go && gen_reg_hit(paddr, pwm_fault_pkg::IDX_CTRL)) begin
            st_next.en[gsel] = pwdata[pwm_fault_pkg::CTRL_EN_BIT];
            st_next.latch[gsel] = pwdata[pwm_fault_pkg::CTRL_LATCH_BIT];
            st_next.minper[gsel] = pwdata[pwm_fault_pkg::CTRL_MINPER_BIT];
            st_next.ext[gsel] = pwdata[pwm_fault_pkg::CTRL_EXT_BIT];
        end
        if (wr_go && gen_reg_hit(paddr, pwm_fault_pkg::IDX_SENSE)) begin
            st_next.sense[gsel] = pwdata[NP-1:0];
        end
        if (wr_go && gen_reg_hit(paddr, pwm_fault_pkg::IDX_MINPER)) begin
            st_next.min_cycles[gsel] = pwdata[pwm_fault_pkg::MIN_W-1:0];
        end
        if (wr_go && gen_reg_hit(paddr, pwm_fault_pkg::IDX_TRIG0)) begin
            st_next.sel0[gsel] = pwdata[NP-1:0];
        end
        if (wr_go && gen_reg_hit(paddr, pwm_fault_pkg::IDX_TRIG1)) begin
            st_next.sel1[gsel] = pwdata[ND-1:0];
        end
        // Write-one-to-clear of latched triggers, per group
        if (wr_go && gen_reg_hit(paddr, pwm_fault_pkg::IDX_STAT0)) begin
            clr0_w[gsel] = pwdata[NP-1:0];
        end
        if (wr_go && gen_reg_hit(paddr, pwm_fault_pkg::IDX_STAT1)) begin
            clr1_w[gsel] = pwdata[ND-1:0];
        end
        // Read mux; unused upper bits read as zero
        if (rd_setup) begin
            st_next.rdata = '0;
            if (paddr == pwm_fault_pkg::OFF_INT_STATUS) begin
                st_next.rdata[NG-1:0] = st_reg.int_status;
            end else if (paddr == pwm_fault_pkg::OFF_INT_MASK) begin
                st_next.rdata[NG-1:0] = st_reg.int_mask;
            end else if (is_mapped(paddr)) begin
                case (idx)
                    pwm_fault_pkg::IDX_CTRL: begin
                        st_next.rdata[pwm_fault_pkg::CTRL_EN_BIT] =
                            st_reg.en[gsel];
                        st_next.rdata[pwm_fault_pkg::CTRL_LATCH_BIT] =
                            st_reg.latch[gsel];
                        st_next.rdata[pwm_fault_pkg::CTRL_MINPER_BIT] =
                            st_reg.minper[gsel];
                        st_next.rdata[pwm_fault_pkg::CTRL_EXT_BIT] =
                            st_reg.ext[gsel];
                    end
                    pwm_fault_pkg::IDX_SENSE: begin
                        st_next.rdata[NP-1:0] = st_reg.sense[gsel];
                    end
                    pwm_fault_pkg::IDX_MINPER: begin
                        st_next.rdata[pwm_fault_pkg::MIN_W-1:0] =
                            st_reg.min_cycles[gsel];
                    end
                    pwm_fault_pkg::IDX_TRIG0: begin
                        st_next.rdata[NP-1:0] = st_reg.sel0[gsel];
                    end
                    pwm_fault_pkg::IDX_TRIG1: begin
                        st_next.rdata[ND-1:0] = st_reg.sel1[gsel];
                    end
                    pwm_fault_pkg::IDX_STAT0: begin
                        st_next.rdata[NP-1:0] = stat0_w[gsel];
                    end
                    pwm_fault_pkg::IDX_STAT1: begin
                        st_next.rdata[ND-1:0] = stat1_w[gsel];
                    end
                    pwm_fault_pkg::IDX_COUNT: begin
                        st_next.rdata[pwm_fault_pkg::CNT_W-1:0] =
                            st_reg.count[gsel];
                    end
                    default: begin
                        st_next.rdata = '0;
                    end
                endcase
            end
        end
    end

    // Only external input zero is selected out of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            for (int g = 0; g < NG; g++) begin
                st_reg.sel0[g] <= pwm_fault_pkg::SEL0_RST;
                st_reg.sel1[g] <= pwm_fault_pkg::SEL1_RST;
                st_reg.sense[g] <= pwm_fault_pkg::SENSE_RST;
                st_reg.min_cycles[g] <= pwm_fault_pkg::MIN_RST;
            end
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Zero-wait slave: every access phase completes at once
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~is_mapped(paddr);
    assign prdata = st_reg.rdata;
    assign count_advance = st_reg.en;
    assign gen_fault = fault_w;
    assign irq = |(st_reg.int_status & st_reg.int_mask);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    for (genvar g = 0; g < NG; g++) begin : gen_chk
        property p_cnt_hold;
            @(posedge pclk) disable iff (!presetn)
            !st_reg.en[g] |=> $stable(st_reg.count[g]);
        endproperty
        a_cnt_hold: assert property (p_cnt_hold)
            else $error("disabled counter moved");

        property p_cnt_step;
            @(posedge pclk) disable iff (!presetn)
            (st_reg.en[g] ##1 st_reg.en[g]) |->
                st_reg.count[g] ==
                $past(st_reg.count[g]) + pwm_fault_pkg::CNT_ONE;
        endproperty
        a_cnt_step: assert property (p_cnt_step)
            else $error("enabled counter did not advance");
    end

    sequence s_rd(logic [pwm_fault_pkg::IDX_W-1:0] want);
        psel && !penable && !pwrite && paddr[1:0] == 2'h0 &&
            gen_reg_hit(paddr, want) ##1 psel && penable;
    endsequence

    property p_stat_read;
        @(posedge pclk) disable iff (!presetn)
        s_rd(pwm_fault_pkg::IDX_STAT0) |->
            prdata[NP-1:0] == $past(stat0_w[gsel]);
    endproperty
    a_stat_read: assert property (p_stat_read)
        else $error("trigger status read mismatch");

    property p_trig_read;
        @(posedge pclk) disable iff (!presetn)
        s_rd(pwm_fault_pkg::IDX_TRIG1) |->
            prdata[ND-1:0] == $past(st_reg.sel1[gsel]);
    endproperty
    a_trig_read: assert property (p_trig_read)
        else $error("trigger selection read mismatch");

    property p_irq_onset;
        @(posedge pclk) disable iff (!presetn)
        (fault_w[0] && !st_reg.fault_prev[0] && st_reg.int_mask[0]) |=> irq;
    endproperty
    a_irq_onset: assert property (p_irq_onset)
        else $error("fault onset raised no interrupt");

endmodule // pwm_fault_trigger_logic

// *** src/pwm_fault_pkg.sv ***
package pwm_fault_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_GEN = 4;
    localparam int NUM_PIN = 4;
    localparam int NUM_DCMP = 8;
    localparam int CNT_W = 16;
    localparam int MIN_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int GEN_W = 2;
    localparam int IDX_W = 3;

    // ------------------------------------------------------------
    // Address layout: one 32-byte block per generator, globals above
    // ------------------------------------------------------------
    localparam int GEN_LSB = 5;
    localparam int IDX_LSB = 2;
    localparam int GLOBAL_BIT = 7;
    localparam logic [1:0] ALIGN_OK = 2'h0;
    localparam logic [IDX_W-1:0] IDX_CTRL = 3'h0;
    localparam logic [IDX_W-1:0] IDX_SENSE = 3'h1;
    localparam logic [IDX_W-1:0] IDX_MINPER = 3'h2;
    localparam logic [IDX_W-1:0] IDX_TRIG0 = 3'h3;
    localparam logic [IDX_W-1:0] IDX_TRIG1 = 3'h4;
    localparam logic [IDX_W-1:0] IDX_STAT0 = 3'h5;
    localparam logic [IDX_W-1:0] IDX_STAT1 = 3'h6;
    localparam logic [IDX_W-1:0] IDX_COUNT = 3'h7;
    localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 8'h80;
    localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h84;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_LATCH_BIT = 1;
    localparam int CTRL_MINPER_BIT = 2;
    localparam int CTRL_EXT_BIT = 3;

    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [NUM_PIN-1:0] SEL0_RST = 4'h1;
    localparam logic [NUM_DCMP-1:0] SEL1_RST = 8'h00;
    localparam logic [NUM_PIN-1:0] SENSE_RST = 4'h0;
    localparam logic [MIN_W-1:0] MIN_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [MIN_W-1:0] MIN_ONE = 16'h0001;
    localparam logic fault_sense_active_high = 1'b0;
    localparam logic fault_sense_active_low = 1'b1;

endpackage

// *** src/fault_if.sv ***
`timescale 1ns/1ps
// Configuration down to one generator's fault unit, state back up
interface fault_if;
    logic [pwm_fault_pkg::NUM_PIN-1:0] sense;
    logic [pwm_fault_pkg::NUM_PIN-1:0] sel0;
    logic [pwm_fault_pkg::NUM_DCMP-1:0] sel1;
    logic [pwm_fault_pkg::MIN_W-1:0] minimum_fault_cycles;
    logic latched_fault_mode;
    logic min_fault_period_mode;
    logic extended_fault_source_mode;
    logic [pwm_fault_pkg::NUM_PIN-1:0] clr0;
    logic [pwm_fault_pkg::NUM_DCMP-1:0] clr1;
    logic [pwm_fault_pkg::NUM_PIN-1:0] stat0;
    logic [pwm_fault_pkg::NUM_DCMP-1:0] stat1;
    logic fault;

    modport cfg (
        output sense, sel0, sel1, minimum_fault_cycles, latched_fault_mode,
        output min_fault_period_mode, extended_fault_source_mode, clr0, clr1,
        input stat0, stat1, fault
    );
    modport unit (
        input sense, sel0, sel1, minimum_fault_cycles, latched_fault_mode,
        input min_fault_period_mode, extended_fault_source_mode, clr0, clr1,
        output stat0, stat1, fault
    );
endinterface // fault_if

// *** src/fault_unit.sv ***
`timescale 1ns/1ps
module fault_unit #(
    parameter bit HAS_EXT = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [pwm_fault_pkg::NUM_PIN-1:0] external_fault_input,
    input wire logic [pwm_fault_pkg::NUM_DCMP-1:0] dcmp_trig,
    fault_if.unit f
);

    typedef struct packed {
        logic [pwm_fault_pkg::NUM_PIN-1:0] latch0;
        logic [pwm_fault_pkg::NUM_DCMP-1:0] latch1;
        logic [pwm_fault_pkg::MIN_W-1:0] cnt;
        logic fault;
    } unit_state_t;

    unit_state_t st_reg;
    unit_state_t st_next;
    logic ext_on;
    logic latch_on;
    logic minper_on;
    logic [pwm_fault_pkg::NUM_PIN-1:0] live0;
    logic src;

    // ------------------------------------------------------------
    // Fault combining, latching and stretching
    // ------------------------------------------------------------
    // Variants without extended handling keep all three modes off
    always_comb begin
        ext_on = HAS_EXT & f.extended_fault_source_mode;
        latch_on = HAS_EXT & f.latched_fault_mode;
        minper_on = HAS_EXT & f.min_fault_period_mode;
        st_next = st_reg;
        live0 = external_fault_input ^ f.sense;
        // Set wins over clear; clear only the selected bits
        if (latch_on) begin
            st_next.latch0 = (st_reg.latch0 & ~f.clr0) | live0;
            st_next.latch1 = (st_reg.latch1 & ~f.clr1) | dcmp_trig;
        end else begin
            st_next.latch0 = '0;
            st_next.latch1 = '0;
        end
        f.stat0 = latch_on ? st_reg.latch0 : live0;
        f.stat1 = latch_on ? st_reg.latch1 : dcmp_trig;
        // Legacy source is input zero alone, after its sense
        if (ext_on) begin
            src = |{f.stat0 & f.sel0, f.stat1 & f.sel1};
        end else begin
            src = f.stat0[0];
        end
        // Counter loads on the first faulted cycle and counts down
        if (!minper_on) begin
            st_next.cnt = '0;
        end else if (src && !st_reg.fault) begin
            st_next.cnt = (f.minimum_fault_cycles == '0) ? '0 :
                f.minimum_fault_cycles - pwm_fault_pkg::MIN_ONE;
        end else if (st_reg.cnt != '0) begin
            st_next.cnt = st_reg.cnt - pwm_fault_pkg::MIN_ONE;
        end
        st_next.fault = src | (minper_on & (st_reg.cnt != '0));
        f.fault = st_reg.fault;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_stretch_hold;
        @(posedge pclk) disable iff (!presetn)
        (minper_on && st_reg.fault && st_reg.cnt != '0) |=> st_reg.fault;
    endproperty
    a_stretch_hold: assert property (p_stretch_hold)
        else $error("fault dropped before minimum period");

    property p_no_stretch;
        @(posedge pclk) disable iff (!presetn)
        (!minper_on && !src) |=> !st_reg.fault;
    endproperty
    a_no_stretch: assert property (p_no_stretch)
        else $error("fault stretched with minimum period off");

    property p_legacy_src;
        @(posedge pclk) disable iff (!presetn)
        (!ext_on && !latch_on && !minper_on)
            |=> st_reg.fault == $past(live0[0]);
    endproperty
    a_legacy_src: assert property (p_legacy_src)
        else $error("legacy mode did not follow input zero");

    property p_or_sel;
        @(posedge pclk) disable iff (!presetn)
        (ext_on && !latch_on &&
            ((live0 & f.sel0) != '0 || (dcmp_trig & f.sel1) != '0))
            |=> st_reg.fault;
    endproperty
    a_or_sel: assert property (p_or_sel)
        else $error("selected asserted input gave no fault");

    property p_latch_keep;
        @(posedge pclk) disable iff (!presetn)
        (latch_on && f.clr0 == '0 && f.clr1 == '0) |=>
            ((st_reg.latch0 & $past(st_reg.latch0)) ==
                $past(st_reg.latch0)) &&
            ((st_reg.latch1 & $past(st_reg.latch1)) ==
                $past(st_reg.latch1));
    endproperty
    a_latch_keep: assert property (p_latch_keep)
        else $error("latched trigger lost without clear");

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        (latch_on && (f.clr0 != '0 || f.clr1 != '0)) |=>
            ((st_reg.latch0 & $past(f.clr0) & ~$past(live0)) == '0) &&
            ((st_reg.latch1 & $past(f.clr1) & ~$past(dcmp_trig)) == '0);
    endproperty
    a_clear: assert property (p_clear)
        else $error("selected latched trigger not cleared");

endmodule // fault_unit

// *** verification/test_pwm_fault_trigger_logic.sv ***
`timescale 1ns/1ps
module test_pwm_fault_trigger_logic;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [3:0] pins = 4'h0;
    logic [3:0][7:0] dcmp = '0;
    logic [3:0] count_advance;
    logic [3:0] gen_fault;
    logic [31:0] rd;
    logic [31:0] r2;
    logic err;
    int miscompares = 0;
    int total_checks = 0;
    // Free-running bus clock, 100 MHz
    always #5 pclk = ~pclk;
    pwm_fault_trigger_logic uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_fault_input(pins), .dcmp_trig(dcmp),
        .count_advance(count_advance), .gen_fault(gen_fault), .irq(irq));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task conclude;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits on pready, never on a fixed count
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            miscompares++;
            conclude();
        end
    endtask
    function automatic logic [7:0] ra(input logic [1:0] g,
        input logic [2:0] idx);
        return {1'b0, g, idx, 2'b00};
    endfunction
    task wr(input logic [1:0] g, input logic [2:0] idx, input int d);
        apb(1'b1, ra(g, idx), 32'(d));
    endtask
    task rdc(input logic [1:0] g, input logic [2:0] idx, input int e);
        apb(1'b0, ra(g, idx), 32'h0);
        chk(rd, 32'(e));
    endtask
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        rdc(0, pwm_fault_pkg::IDX_TRIG0, 1);
        chk(count_advance, 0);
        chk(gen_fault, 0);
        $display("reset values done");
    endtask
    // Counter must move only while its generator is enabled
    task t_count;
        wr(1, pwm_fault_pkg::IDX_CTRL, 1);
        cyc(1);
        chk(count_advance, 4'h2);
        // Enabled from the write edge; two steps before the setup edge
        rdc(1, pwm_fault_pkg::IDX_COUNT, 2);
        r2 = rd;
        apb(1'b0, ra(1, pwm_fault_pkg::IDX_COUNT), 0);
        chk(rd - r2, 3);
        wr(1, pwm_fault_pkg::IDX_CTRL, 0);
        apb(1'b0, ra(1, pwm_fault_pkg::IDX_COUNT), 0);
        r2 = rd;
        apb(1'b0, ra(1, pwm_fault_pkg::IDX_COUNT), 0);
        chk(rd, r2);
        $display("counter gating done");
    endtask
    task t_sense;
        wr(0, pwm_fault_pkg::IDX_SENSE, 1);
        cyc(3);
        chk(gen_fault[0], 1);
        rdc(0, pwm_fault_pkg::IDX_STAT0, 1);
        pins <= 4'h1;
        cyc(3);
        chk(gen_fault[0], 0);
        pins <= 4'h0;
        wr(0, pwm_fault_pkg::IDX_SENSE, 0);
        $display("pin sense done");
    endtask
    // One-cycle pulse: stretched on gen1 only, plain on gen0
    task t_minper;
        int n0;
        int n1;
        n0 = 0;
        n1 = 0;
        wr(1, pwm_fault_pkg::IDX_MINPER, 5);
        wr(1, pwm_fault_pkg::IDX_CTRL, 4);
        pins <= 4'h1;
        cyc(1);
        pins <= 4'h0;
        repeat (12) begin
            @(posedge pclk);
            n0 += int'(gen_fault[0]);
            n1 += int'(gen_fault[1]);
        end
        chk(n1 >= 5, 1);
        chk(n0, 1);
        $display("minimum period done");
    endtask
    task t_ext;
        wr(2, pwm_fault_pkg::IDX_CTRL, 8);
        wr(2, pwm_fault_pkg::IDX_TRIG0, 0);
        wr(2, pwm_fault_pkg::IDX_TRIG1, 8);
        rdc(2, pwm_fault_pkg::IDX_TRIG1, 8);
        dcmp[2] <= 8'h04;
        cyc(3);
        chk(gen_fault[2], 0);
        dcmp[2] <= 8'h08;
        cyc(3);
        chk(gen_fault[2], 1);
        rdc(2, pwm_fault_pkg::IDX_STAT1, 8);
        dcmp[2] <= 8'h00;
        $display("extended sources done");
    endtask
    // Two triggers latch; clearing one must leave the other
    task t_latch;
        wr(3, pwm_fault_pkg::IDX_CTRL, 10);
        wr(3, pwm_fault_pkg::IDX_TRIG0, 0);
        wr(3, pwm_fault_pkg::IDX_TRIG1, 1);
        dcmp[3] <= 8'h03;
        cyc(1);
        dcmp[3] <= 8'h00;
        cyc(3);
        chk(gen_fault[3], 1);
        rdc(3, pwm_fault_pkg::IDX_STAT1, 3);
        wr(3, pwm_fault_pkg::IDX_STAT1, 1);
        rdc(3, pwm_fault_pkg::IDX_STAT1, 2);
        cyc(2);
        chk(gen_fault[3], 0);
        $display("latched faults done");
    endtask
    task t_irq;
        apb(1'b1, pwm_fault_pkg::OFF_INT_STATUS, 32'hf);
        apb(1'b0, pwm_fault_pkg::OFF_INT_STATUS, 0);
        chk(rd, 0);
        chk(irq, 0);
        apb(1'b1, pwm_fault_pkg::OFF_INT_MASK, 1);
        pins <= 4'h1;
        cyc(1);
        pins <= 4'h0;
        cyc(3);
        chk(irq, 1);
        apb(1'b1, pwm_fault_pkg::OFF_INT_MASK, 0);
        cyc(1);
        chk(irq, 0);
        apb(1'b0, 8'h88, 0);
        chk(err, 1);
        chk(rd, 0);
        $display("interrupt and map done");
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_count();
        t_sense();
        t_minper();
        t_ext();
        t_latch();
        t_irq();
        conclude();
    end
endmodule // test_pwm_fault_trigger_logic
